// [verilog/rssa_core.sv]
// Rotate, subtract-with-borrow and skip datapath behind an AXI4-Lite register slave
//
// Contract
// (RL1) Rotate memory byte left, bit 7 into bit 0, write back, no flags.
// (RL2) Left rotation of memory byte goes to work register; memory and flags kept.
// (RL3) Nine-bit left ring with carry: bit 7 to carry, carry to bit 0, to memory.
// (RL4) Same nine-bit left ring, result to work register, carry updated, memory kept.
// (RL5) Rotate memory byte right, bit 0 into bit 7, write back, no flags.
// (RL6) Right rotation of memory byte goes to work register; memory and flags kept.
// (RL7) Nine-bit right ring with carry: bit 0 to carry, carry to bit 7, to memory.
// (RL8) Same nine-bit right ring, result to work register, carry updated, memory kept.
// (RL9) Work plus inverted byte plus carry into work; update four arithmetic flags.
// (RL10) Same sum stored into memory byte; update four arithmetic flags.
// (RL11) Decrement memory byte, write back; zero result skips next slot; no flags.
// (RL12) Byte minus one into work register; memory kept; skip on zero; no flags.
// (RL13) A taken skip discards the prefetched slot and adds one dummy cycle.
// (RL14) Write all ones into memory byte; flags unchanged.
// (RL15) Force selected bit of memory byte to one; other bits and flags unchanged.
// (RL16) Increment memory byte, write back; wrap to zero skips next slot; no flags.
// (RL17) Byte plus one into work register; memory kept; skip on zero; no flags.
// (RL18) Skip next slot when selected bit is one; no flag change.
// (RL19) Carry from bit 7, half carry from bit 3, zero result, signed wrap.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rssa_core #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic discardFetch,
    output logic opDone
);
    // Write and read channel holding registers
    logic awHeld_ff;
    logic wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic arReady_ff;
    logic rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0] rResp_ff;

    // Architectural state
    logic [W-1:0] memByte_ff;
    logic [W-1:0] work_ff;
    logic [3:0] flags_ff;
    logic [4:0] cmdOp_ff;
    logic [2:0] cmdBit_ff;
    logic lastSkip_ff;
    logic badOp_ff;
    logic [7:0] doneCnt_ff;
    logic discard_ff;
    logic done_ff;

    logic [W-1:0] nxt_memByte;
    logic [W-1:0] nxt_work;
    logic [3:0] nxt_flags;

    // Byte lane mask of the held write
    logic [31:0] laneMask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gLane
            assign laneMask[gi*8 +: 8] = {8{wStrb_ff[gi]}};
        end
    endgenerate

    wire doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
    wire hitCmd = (awAddr_ff == rssa_pkg::ADDR_CMD);
    wire hitMem = (awAddr_ff == rssa_pkg::ADDR_MEM);
    wire hitWork = (awAddr_ff == rssa_pkg::ADDR_WORK);
    wire hitFlags = (awAddr_ff == rssa_pkg::ADDR_FLAGS);
    wire hitStat = (awAddr_ff == rssa_pkg::ADDR_STATUS);
    wire wrMapped = hitCmd || hitMem || hitWork || hitFlags || hitStat;
    wire [31:0] cmdWord = {16'h0000, 5'h00, cmdBit_ff, 3'h0, cmdOp_ff};
    wire [31:0] cmdMerged = (cmdWord & ~laneMask) | (wData_ff & laneMask);
    wire [31:0] memMerged = ({24'h0000_00, memByte_ff} & ~laneMask) | (wData_ff & laneMask);
    wire [31:0] workMerged = ({24'h0000_00, work_ff} & ~laneMask) | (wData_ff & laneMask);
    wire [31:0] flagMerged = ({28'h000_0000, flags_ff} & ~laneMask) | (wData_ff & laneMask);

    // Sequencer and operation unit
    logic execNow;
    logic dummyNow;
    logic busy;
    logic [W-1:0] calcResult;
    logic calcToMem;
    logic calcToWork;
    logic calcCarryWr;
    logic calcCarry;
    logic calcArithWr;
    logic calcHalf;
    logic calcZero;
    logic calcWrap;
    logic calcSkip;
    logic calcBad;

    // Starting only from a command write with lane 0 present keeps half-written commands inert
    wire startOp = doWrite && hitCmd && wStrb_ff[0] && !busy;

    rssa_skip u_seq (
        .clk(clk),
        .rst_b(rst_b),
        .start(startOp),
        .skipTaken(calcSkip && !calcBad),
        .execNow(execNow),
        .dummyNow(dummyNow),
        .busy(busy)
    );

    rssa_calc #(
        .W(W)
    ) u_calc (
        .opCode(cmdOp_ff),
        .bitSel(cmdBit_ff),
        .memIn(memByte_ff),
        .workIn(work_ff),
        .carryIn(flags_ff[rssa_pkg::FLAG_C]),
        .result(calcResult),
        .toMem(calcToMem),
        .toWork(calcToWork),
        .carryWr(calcCarryWr),
        .carryOut(calcCarry),
        .arithWr(calcArithWr),
        .halfOut(calcHalf),
        .zeroOut(calcZero),
        .wrapOut(calcWrap),
        .skip(calcSkip),
        .badOp(calcBad)
    );

    // Execution results win over a software write in the same cycle
    wire swMem = doWrite && hitMem;
    wire swWork = doWrite && hitWork;
    wire swFlags = doWrite && hitFlags;
    wire hwMem = execNow && calcToMem;
    wire hwWork = execNow && calcToWork;
    assign nxt_memByte = hwMem ? calcResult : (swMem ? memMerged[W-1:0] : memByte_ff); // RL1
    assign nxt_work = hwWork ? calcResult : (swWork ? workMerged[W-1:0] : work_ff); // RL2

    always_comb begin
        nxt_flags = swFlags ? flagMerged[3:0] : flags_ff;
        if (execNow && calcCarryWr) begin
            nxt_flags[rssa_pkg::FLAG_C] = calcCarry; // RL3
        end
        if (execNow && calcArithWr) begin
            nxt_flags[rssa_pkg::FLAG_AC] = calcHalf; // RL19
            nxt_flags[rssa_pkg::FLAG_Z] = calcZero; // RL19
            nxt_flags[rssa_pkg::FLAG_OV] = calcWrap; // RL19
        end
    end

    // Read decode
    wire [31:0] statWord = {16'h0000, doneCnt_ff, 5'h00, badOp_ff, lastSkip_ff, busy};
    wire rdCmd = (s_axi_araddr == rssa_pkg::ADDR_CMD);
    wire rdMem = (s_axi_araddr == rssa_pkg::ADDR_MEM);
    wire rdWork = (s_axi_araddr == rssa_pkg::ADDR_WORK);
    wire rdFlags = (s_axi_araddr == rssa_pkg::ADDR_FLAGS);
    wire rdStat = (s_axi_araddr == rssa_pkg::ADDR_STATUS);
    wire rdMapped = rdCmd || rdMem || rdWork || rdFlags || rdStat;
    wire [31:0] rdWord = rdCmd ? cmdWord :
                         rdMem ? {24'h0000_00, memByte_ff} :
                         rdWork ? {24'h0000_00, work_ff} :
                         rdFlags ? {28'h000_0000, flags_ff} :
                         rdStat ? statWord : 32'h0000_0000;
    wire arTake = s_axi_arvalid && arReady_ff;

    // Write address and data are taken independently
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
        end else if (s_axi_awvalid && !awHeld_ff) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
        end else if (s_axi_wvalid && !wHeld_ff) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bValid_ff <= 1'b0;
            bResp_ff <= rssa_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff <= wrMapped ? rssa_pkg::RESP_OKAY : rssa_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    // One read in flight; address is taken only while no data waits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arReady_ff <= 1'b0;
            rValid_ff <= 1'b0;
            rData_ff <= 32'h0000_0000;
            rResp_ff <= rssa_pkg::RESP_OKAY;
        end else if (arTake) begin
            arReady_ff <= 1'b0;
            rValid_ff <= 1'b1;
            rData_ff <= rdWord;
            rResp_ff <= rdMapped ? rssa_pkg::RESP_OKAY : rssa_pkg::RESP_SLVERR;
        end else if (rValid_ff && s_axi_rready) begin
            rValid_ff <= 1'b0;
        end else if (!rValid_ff) begin
            arReady_ff <= 1'b1;
        end
    end

    // Command register is frozen while an operation is under way
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdOp_ff <= 5'h00;
            cmdBit_ff <= 3'h0;
        end else if (doWrite && hitCmd && !busy) begin
            cmdOp_ff <= cmdMerged[rssa_pkg::CMD_OP_LSB +: rssa_pkg::CMD_OP_W];
            cmdBit_ff <= cmdMerged[rssa_pkg::CMD_BIT_LSB +: rssa_pkg::CMD_BIT_W];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memByte_ff <= rssa_pkg::RST_BYTE;
            work_ff <= rssa_pkg::RST_BYTE;
            flags_ff <= rssa_pkg::RST_FLAGS;
        end else begin
            memByte_ff <= nxt_memByte;
            work_ff <= nxt_work;
            flags_ff <= nxt_flags;
        end
    end

    // Outcome of the last operation, kept until the next one executes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lastSkip_ff <= 1'b0;
            badOp_ff <= 1'b0;
            doneCnt_ff <= 8'h00;
        end else if (execNow) begin
            lastSkip_ff <= calcSkip && !calcBad; // RL11
            badOp_ff <= calcBad;
            doneCnt_ff <= doneCnt_ff + 8'h01;
        end
    end

    // Discard marker stands for the dummy cycle; done pulses when the slot count ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            discard_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            discard_ff <= execNow && calcSkip && !calcBad; // RL13
            done_ff <= (execNow && !(calcSkip && !calcBad)) || dummyNow; // RL16
        end
    end

    assign s_axi_awready = !awHeld_ff;
    assign s_axi_wready = !wHeld_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_arready = arReady_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;
    assign discardFetch = discard_ff;
    assign opDone = done_ff;

endmodule : rssa_core

// [verilog/rssa_pkg.sv]
// Shared constants, operation codes and register map of the rotate/subtract/skip datapath
package rssa_pkg;

    localparam int DATA_W = 8;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_MEM = 8'h04;
    localparam logic [7:0] ADDR_WORK = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Command fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 5;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_BIT_W = 3;

    // Flag register fields
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;

    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_SKIP = 1;
    localparam int STAT_BAD_OP = 2;
    localparam int STAT_DONE_CNT_LSB = 8;
    localparam int STAT_DONE_CNT_W = 8;

    // Reset values and byte constants
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ONE_BYTE = 8'h01;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Cycle counts of an execution
    localparam int EXEC_CYCLES = 1;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [4:0] {
        OP_ROTATE_LEFT_MEM = 5'h00,
        OP_ROTATE_LEFT_TO_WORK = 5'h01,
        OP_ROTATE_LEFT_THRU_FLAG = 5'h02,
        OP_ROTATE_LEFT_THRU_FLAG_TO_WORK = 5'h03,
        OP_ROTATE_RIGHT_MEM = 5'h04,
        OP_ROTATE_RIGHT_TO_WORK = 5'h05,
        OP_ROTATE_RIGHT_THRU_FLAG = 5'h06,
        OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK = 5'h07,
        OP_SUBTRACT_WITH_BORROW = 5'h08,
        OP_SUBTRACT_WITH_BORROW_STORE = 5'h09,
        OP_DECREMENT_SKIP_ZERO = 5'h0A,
        OP_DECREMENT_TO_WORK_SKIP_ZERO = 5'h0B,
        OP_SET_BYTE = 5'h0C,
        OP_SET_BIT = 5'h0D,
        OP_INCREMENT_SKIP_ZERO = 5'h0E,
        OP_INCREMENT_TO_WORK_SKIP_ZERO = 5'h0F,
        OP_BIT_TEST_SKIP_NONZERO = 5'h10
    } rssa_op_t;

    // Gray coded along idle -> execute -> dummy
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b11
    } rssa_state_t;

endpackage : rssa_pkg

// [verilog/rssa_calc.sv]
// Combinational result, flag and skip logic for one operation
`timescale 1ns/1ps
module rssa_calc #(
    parameter int W = 8
) (
    input wire logic [4:0] opCode,
    input wire logic [2:0] bitSel,
    input wire logic [W-1:0] memIn,
    input wire logic [W-1:0] workIn,
    input wire logic carryIn,
    output logic [W-1:0] result,
    output logic toMem,
    output logic toWork,
    output logic carryWr,
    output logic carryOut,
    output logic arithWr,
    output logic halfOut,
    output logic zeroOut,
    output logic wrapOut,
    output logic skip,
    output logic badOp
);
    logic [W:0] diffSum;
    logic [4:0] halfSum;
    logic [W-1:0] decVal;
    logic [W-1:0] incVal;
    logic [W-1:0] bitMask;

    assign diffSum = {1'b0, workIn} + {1'b0, ~memIn} + {{W{1'b0}}, carryIn};
    assign halfSum = {1'b0, workIn[3:0]} + {1'b0, ~memIn[3:0]} + {4'h0, carryIn};
    assign decVal = memIn - rssa_pkg::ONE_BYTE;
    assign incVal = memIn + rssa_pkg::ONE_BYTE;
    assign bitMask = rssa_pkg::ONE_BYTE << bitSel;

    always_comb begin
        result = memIn;
        toMem = 1'b0;
        toWork = 1'b0;
        carryWr = 1'b0;
        carryOut = carryIn;
        arithWr = 1'b0;
        halfOut = halfSum[4];
        zeroOut = (diffSum[W-1:0] == '0);
        wrapOut = (workIn[W-1] == ~memIn[W-1]) && (diffSum[W-1] != workIn[W-1]);
        skip = 1'b0;
        badOp = 1'b0;
        unique case (opCode)
            rssa_pkg::OP_ROTATE_LEFT_MEM: begin
                result = {memIn[W-2:0], memIn[W-1]}; // RL1
                toMem = 1'b1;
            end
            rssa_pkg::OP_ROTATE_LEFT_TO_WORK: begin
                result = {memIn[W-2:0], memIn[W-1]}; // RL2
                toWork = 1'b1;
            end
            rssa_pkg::OP_ROTATE_LEFT_THRU_FLAG,
            rssa_pkg::OP_ROTATE_LEFT_THRU_FLAG_TO_WORK: begin
                result = {memIn[W-2:0], carryIn}; // RL3 RL4
                carryWr = 1'b1;
                carryOut = memIn[W-1];
                toMem = (opCode == rssa_pkg::OP_ROTATE_LEFT_THRU_FLAG);
                toWork = !toMem;
            end
            rssa_pkg::OP_ROTATE_RIGHT_MEM: begin
                result = {memIn[0], memIn[W-1:1]}; // RL5
                toMem = 1'b1;
            end
            rssa_pkg::OP_ROTATE_RIGHT_TO_WORK: begin
                result = {memIn[0], memIn[W-1:1]}; // RL6
                toWork = 1'b1;
            end
            rssa_pkg::OP_ROTATE_RIGHT_THRU_FLAG,
            rssa_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_WORK: begin
                result = {carryIn, memIn[W-1:1]}; // RL7 RL8
                carryWr = 1'b1;
                carryOut = memIn[0];
                toMem = (opCode == rssa_pkg::OP_ROTATE_RIGHT_THRU_FLAG);
                toWork = !toMem;
            end
            rssa_pkg::OP_SUBTRACT_WITH_BORROW,
            rssa_pkg::OP_SUBTRACT_WITH_BORROW_STORE: begin
                result = diffSum[W-1:0]; // RL9 RL10
                arithWr = 1'b1; // RL19
                carryWr = 1'b1;
                carryOut = diffSum[W]; // RL19
                toMem = (opCode == rssa_pkg::OP_SUBTRACT_WITH_BORROW_STORE);
                toWork = !toMem;
            end
            rssa_pkg::OP_DECREMENT_SKIP_ZERO,
            rssa_pkg::OP_DECREMENT_TO_WORK_SKIP_ZERO: begin
                result = decVal; // RL11 RL12
                skip = (decVal == '0);
                toMem = (opCode == rssa_pkg::OP_DECREMENT_SKIP_ZERO);
                toWork = !toMem;
            end
            rssa_pkg::OP_SET_BYTE: begin
                result = rssa_pkg::ALL_ONES; // RL14
                toMem = 1'b1;
            end
            rssa_pkg::OP_SET_BIT: begin
                result = memIn | bitMask; // RL15
                toMem = 1'b1;
            end
            rssa_pkg::OP_INCREMENT_SKIP_ZERO,
            rssa_pkg::OP_INCREMENT_TO_WORK_SKIP_ZERO: begin
                result = incVal; // RL16 RL17
                skip = (incVal == '0);
                toMem = (opCode == rssa_pkg::OP_INCREMENT_SKIP_ZERO);
                toWork = !toMem;
            end
            rssa_pkg::OP_BIT_TEST_SKIP_NONZERO: begin
                skip = |(memIn & bitMask); // RL18
            end
            default: begin
                badOp = 1'b1;
            end
        endcase
    end

endmodule : rssa_calc

// [verilog/rssa_skip.sv]
// Execution sequencer: one execute cycle, plus a dummy cycle when a skip is taken
`timescale 1ns/1ps
module rssa_skip (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic skipTaken,
    output logic execNow,
    output logic dummyNow,
    output logic busy
);
    rssa_pkg::rssa_state_t state_ff;
    rssa_pkg::rssa_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rssa_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_state = rssa_pkg::ST_EXEC;
                end
            end
            rssa_pkg::ST_EXEC: begin
                // The prefetched slot is thrown away in a dummy cycle
                nxt_state = skipTaken ? rssa_pkg::ST_DUMMY : rssa_pkg::ST_IDLE; // RL13
            end
            rssa_pkg::ST_DUMMY: begin
                nxt_state = rssa_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = rssa_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= rssa_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign execNow = (state_ff == rssa_pkg::ST_EXEC);
    assign dummyNow = (state_ff == rssa_pkg::ST_DUMMY);
    assign busy = (state_ff != rssa_pkg::ST_IDLE);

endmodule : rssa_skip

// [tb/rssa_asserts.sv]
// Checker for bus handshakes and skip sequencing of the datapath
`timescale 1ns/1ps
module rssa_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic discardFetch,
    input wire logic opDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_skip_then_done: assert property (discardFetch |=> opDone)
        else $error("Done did not follow the dummy cycle");
    a_dummy_single: assert property (discardFetch |=> !discardFetch)
        else $error("Dummy cycle longer than one cycle");
    a_done_apart: assert property (!(discardFetch && opDone))
        else $error("Done during the dummy cycle");
    a_done_pulse: assert property (opDone |=> !opDone)
        else $error("Done held over two cycles");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("Write answer late");
    cover property (discardFetch);
    cover property (opDone && !$past(discardFetch));
    cover property (s_axi_bvalid && s_axi_bresp == rssa_pkg::RESP_SLVERR);
endmodule : rssa_asserts

bind rssa_core rssa_asserts u_chk (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .discardFetch, .opDone);

// [tb/tb_top.sv]
// Register-level testbench of the rotate/subtract/skip datapath
`timescale 1ns/1ps
module tb_top;
    logic clk = '0;
    logic rst_b = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic discardFetch, opDone;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_fail = 0, n_compared = 0, cyc = 0, opCnt = 0;
    // Operand sets chosen to hit wraps, zero results and both bit values
    logic [7:0] vm [3] = '{8'h81, 8'h01, 8'hFF};
    logic [7:0] vw [3] = '{8'h3C, 8'h00, 8'hFF};
    logic [3:0] vf [3] = '{4'h1, 4'hA, 4'h5};
    logic [2:0] vb [3] = '{3'h7, 3'h1, 3'h4};

    rssa_core uut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .discardFetch, .opDone);

    always #12.5 clk = ~clk;

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 0, w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && s_axi_awready === 1'b1) begin aw = 1; s_axi_awvalid <= 1'b0; end
            if (!w && s_axi_wready === 1'b1) begin w = 1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd

    // Returns {skip, flags, work, mem}
    function automatic logic [20:0] model(input logic [4:0] op, input logic [2:0] b,
        input logic [7:0] m, input logic [7:0] w, input logic [3:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] nm, nw;
        logic [3:0] nf, af;
        logic sk;
        nm = m; nw = w; nf = f; sk = 1'b0;
        s = {1'b0, w} + {1'b0, ~m} + {8'h00, f[0]};
        h = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + {4'h0, f[0]};
        af = {(w[7] == ~m[7]) && (s[7] != w[7]), s[7:0] == 8'h00, h[4], s[8]};
        case (op)
            5'h00: nm = {m[6:0], m[7]};
            5'h01: nw = {m[6:0], m[7]};
            5'h02: begin nm = {m[6:0], f[0]}; nf[0] = m[7]; end
            5'h03: begin nw = {m[6:0], f[0]}; nf[0] = m[7]; end
            5'h04: nm = {m[0], m[7:1]};
            5'h05: nw = {m[0], m[7:1]};
            5'h06: begin nm = {f[0], m[7:1]}; nf[0] = m[0]; end
            5'h07: begin nw = {f[0], m[7:1]}; nf[0] = m[0]; end
            5'h08: begin nw = s[7:0]; nf = af; end
            5'h09: begin nm = s[7:0]; nf = af; end
            5'h0A: begin nm = m - 8'h01; sk = (m == 8'h01); end
            5'h0B: begin nw = m - 8'h01; sk = (m == 8'h01); end
            5'h0C: nm = rssa_pkg::ALL_ONES;
            5'h0D: nm[b] = 1'b1;
            5'h0E: begin nm = m + 8'h01; sk = (m == 8'hFF); end
            5'h0F: begin nw = m + 8'h01; sk = (m == 8'hFF); end
            default: sk = m[b];
        endcase
        return {sk, nf, nw, nm};
    endfunction : model

    task automatic run_op(input logic [4:0] op, input int v);
        logic [20:0] e;
        logic [31:0] d;
        logic [1:0] r;
        logic dis = 1'b0;
        int k;
        e = model(op, vb[v], vm[v], vw[v], vf[v]);
        wr(rssa_pkg::ADDR_MEM, {24'h00_0000, vm[v]}, r);
        wr(rssa_pkg::ADDR_WORK, {24'h00_0000, vw[v]}, r);
        wr(rssa_pkg::ADDR_FLAGS, {28'h000_0000, vf[v]}, r);
        wr(rssa_pkg::ADDR_CMD, {21'h00_0000, vb[v], 3'h0, op}, r);
        for (k = 0; k < 10 && opDone !== 1'b1; k++) begin
            @(posedge clk);
            if (discardFetch === 1'b1) dis = 1'b1;
        end
        opCnt++;
        rd(rssa_pkg::ADDR_MEM, d, r);
        chk("mem", {24'h00_0000, e[7:0]}, d);
        rd(rssa_pkg::ADDR_WORK, d, r);
        chk("work", {24'h00_0000, e[15:8]}, d);
        rd(rssa_pkg::ADDR_FLAGS, d, r);
        chk("flags", {28'h000_0000, e[19:16]}, d);
        chk("dummy cycle", {31'h0000_0000, e[20]}, {31'h0000_0000, dis});
        chk("cycles", e[20] ? rssa_pkg::SKIP_CYCLES : rssa_pkg::EXEC_CYCLES, k);
        rd(rssa_pkg::ADDR_STATUS, d, r);
        chk("status", {16'h0000, opCnt[7:0], 6'h00, e[20], 1'b0},
            d & 32'h0000_FF07);
    endtask : run_op

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rd(rssa_pkg::ADDR_MEM, d, r);
        chk("mem after reset", 32'h0000_0000, d);
        rd(8'h14, d, r);
        chk("unmapped read resp", {30'h0000_0000, rssa_pkg::RESP_SLVERR}, {30'h0000_0000, r});
        wr(8'h14, 32'hFFFF_FFFF, r);
        chk("unmapped write resp", {30'h0000_0000, rssa_pkg::RESP_SLVERR}, {30'h0000_0000, r});
        for (int v = 0; v < 3; v++)
            for (int op = 0; op < 17; op++) run_op(op[4:0], v);
        // Illegal code last, as its effect on the counter is not pinned down
        wr(rssa_pkg::ADDR_CMD, 32'h0000_0011, r);
        rd(rssa_pkg::ADDR_STATUS, d, r);
        chk("illegal op flag", 32'h0000_0004, d & 32'h0000_0004);
        print_verdict();
    end
endmodule : tb_top
